// [design/sfoc_map.svh]
// register addresses, field layout, reset values and timing counts of the slice
`ifndef SFOC_MAP_SVH
`define SFOC_MAP_SVH
`define SFOC_ADDR_W         15
`define SFOC_ADDR_SYNC      15'h0210
`define SFOC_ADDR_OVR_LVL   15'h0211
`define SFOC_ADDR_OVERRANGE_CONFIG   15'h0213
`define SFOC_ADDR_INIT      15'h0270
`define SFOC_RST_SYNC_LIM   5'h03
`define SFOC_RST_OVR_LVL    8'hf2
`define SFOC_RST_OVERRANGE_OUTPUT_ENABLE     1'h0
`define SFOC_RST_OVR_EXP    3'h7
`define SFOC_SYNC_LIM_MSB   4
`define SFOC_OVERRANGE_OUTPUT_ENABLE_BIT     3
`define SFOC_OVR_EXP_MSB    2
`define SFOC_HOLD_BASE      10'h004
`define SFOC_LEVEL_W        8
`define SFOC_SPI_CMD_LAST   5'h0f
`define SFOC_SPI_DATA_LAST  5'h17
`define SFOC_SPI_SHIFT_W    16
`define SFOC_DATA_W         8
`endif

// [design/sfoc_pkg.sv]
// shared types of the sync qualifier / over-range slice
`include "sfoc_map.svh"
package sfoc_pkg;
  // serial frame phases, one-hot
  typedef enum logic [3:0] {
    SFOC_IDLE = 4'b0001,
    SFOC_ADDR = 4'b0010,
    SFOC_DATA = 4'b0100,
    SFOC_DONE = 4'b1000
  } sfoc_spi_state_e;
  // over-range configuration fields
  typedef struct packed {
    logic       enable;
    logic [2:0] hold_exp;
  } sfoc_overrange_config_s;
  // decoded serial command word
  typedef struct packed {
    logic                    is_read;
    logic [`SFOC_ADDR_W-1:0] addr;
  } sfoc_spi_cmd_s;
endpackage

// [design/sfoc_sync_qual.sv]
// qualifier that turns a run of low sync samples into a request
`timescale 1ns/1ps
`include "sfoc_map.svh"
module sfoc_sync_qual
  import sfoc_pkg::*;
#(
  parameter int LIMIT_W = 5
) (
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // link side, sync already synchronised
  input  wire logic               link_tick_i,
  input  wire logic               link_enable_i,
  input  wire logic               sync_n_i,
  input  wire logic [LIMIT_W-1:0] limit_i,
  // results
  output logic                    request_o,
  output logic                    error_report_o
);
  logic [LIMIT_W:0] run;
  // one bit wider so that limit plus one always fits
  wire  [LIMIT_W:0] run_goal = {1'b0, limit_i} + {{LIMIT_W{1'b0}}, 1'b1};
  wire  [LIMIT_W:0] next_run = run + {{LIMIT_W{1'b0}}, 1'b1};
  // limit assumed static while the link runs, >= tolerates a late change
  wire              run_full = (run >= run_goal);

  // count consecutive low samples on link ticks only
  always_ff @(posedge clock_i) begin
    if (rst_i || !link_enable_i) begin
      run            <= '0;
      request_o      <= 1'b0;
      error_report_o <= 1'b0;
    end else begin
      error_report_o <= 1'b0;
      if (link_tick_i) begin
        if (sync_n_i) begin
          run            <= '0;
          request_o      <= 1'b0;
          error_report_o <= (run != '0) && !request_o;
        end else if (!run_full) begin
          run       <= next_run;
          request_o <= (next_run >= run_goal);
        end
      end
    end
  end

  property p_req_after_run;
    @(posedge clock_i) disable iff (rst_i)
      $rose(request_o) |-> (run == run_goal);
  endproperty
  a_req_after_run: assert property (p_req_after_run) else $error("request before run");

  property p_high_breaks_run;
    @(posedge clock_i) disable iff (rst_i)
      (link_tick_i && sync_n_i) |=> (run == '0) && !request_o;
  endproperty
  a_high_breaks_run: assert property (p_high_breaks_run) else $error("run not cleared");

  property p_short_is_error;
    @(posedge clock_i) disable iff (rst_i)
      error_report_o |-> $past(link_tick_i) && $past(sync_n_i) && !request_o;
  endproperty
  a_short_is_error: assert property (p_short_is_error) else $error("bad error report");

  property p_count_on_tick;
    @(posedge clock_i) disable iff (rst_i)
      (!link_tick_i && link_enable_i) |=> (run == $past(run));
  endproperty
  a_count_on_tick: assert property (p_count_on_tick) else $error("count off tick");
endmodule

// [design/sfoc_ovr_chan.sv]
// one channel of over-range detection with pulse extension
`timescale 1ns/1ps
`include "sfoc_map.svh"
module sfoc_ovr_chan
  import sfoc_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int HOLD_W   = 10
) (
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // sample and settings
  input  wire logic [SAMPLE_W-1:0] sample_i,
  input  wire logic [`SFOC_LEVEL_W-1:0] level_i,
  input  wire sfoc_overrange_config_s       cfg_i,
  // flag
  output logic                     flag_o
);
  localparam int PAD_W = SAMPLE_W - 1 - `SFOC_LEVEL_W;
  logic [HOLD_W-1:0] hold;
  logic [15:0]       hi_run;
  // two's complement magnitude, negative full scale maps to full scale
  wire [SAMPLE_W-1:0] mag = sample_i[SAMPLE_W-1] ? (~sample_i + 1'b1) : sample_i;
  // level is a fraction of 256 of full scale
  wire [SAMPLE_W-1:0] thr = {1'b0, level_i, {PAD_W{1'b0}}};
  wire                detect = (mag >= thr);
  // each exponent step doubles the hold period
  wire [HOLD_W-1:0]   hold_len = HOLD_W'(`SFOC_HOLD_BASE) << cfg_i.hold_exp;

  // extend each detection to at least hold_len sampling cycles
  always_ff @(posedge clock_i) begin
    if (rst_i || !cfg_i.enable) begin
      hold   <= '0;
      flag_o <= 1'b0;
    end else begin
      flag_o <= detect || (hold > HOLD_W'(1));
      if (detect)
        hold <= hold_len;
      else if (hold != '0)
        hold <= hold - HOLD_W'(1);
    end
  end

  // helper: length of the current high run of the flag
  always_ff @(posedge clock_i) begin
    if (rst_i || !flag_o)
      hi_run <= 16'h0001;
    else
      hi_run <= hi_run + 16'h0001;
  end

  property p_detect_sets;
    @(posedge clock_i) disable iff (rst_i)
      (detect && cfg_i.enable) |=> flag_o && (hold == $past(hold_len));
  endproperty
  a_detect_sets: assert property (p_detect_sets) else $error("detect lost");

  property p_disabled_low;
    @(posedge clock_i) disable iff (rst_i)
      !cfg_i.enable |=> !flag_o;
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("flag while disabled");

  property p_min_width;
    @(posedge clock_i) disable iff (rst_i)
      ($fell(flag_o) && $past(cfg_i.enable) && $stable(cfg_i.hold_exp))
        |-> ($past(hi_run) >= 16'($past(hold_len)));
  endproperty
  a_min_width: assert property (p_min_width) else $error("pulse too short");
endmodule

// [design/sfoc_top.sv]
// top of the sync qualifier, over-range and init status slice with its serial port
//
// Notes on behaviour
// - request after limit-plus-one consecutive low samples
// - shorter low pulse is error report, ignored
// - sync sampled and counted on half-rate link tick
// - flag when magnitude reaches programmed level
// - level means level over 256 of full scale
// - disabled over-range holds all four flags low
// - flag pulse lasts four times two-power-exponent
// - each exponent step doubles hold period
// - init done set after init; host waits
`timescale 1ns/1ps
`include "sfoc_map.svh"
module sfoc_top
  import sfoc_pkg::*;
#(
  parameter int SAMPLE_W    = 12,
  parameter int INIT_CYCLES = 16
) (
  // clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  // serial register port pins
  input  wire logic                     spi_sclk_i,
  input  wire logic                     spi_cs_n_i,
  input  wire logic                     spi_sdi_i,
  output logic                          spi_sdo_o,
  output logic                          spi_sdo_oe_o,
  // link side
  input  wire logic                     sync_n_i,
  input  wire logic                     link_enable_i,
  output logic                          sync_request_o,
  output logic                          sync_error_report_o,
  // converter samples, one per channel, same clock
  input  wire logic [3:0][SAMPLE_W-1:0] samples_i,
  // over-range flags
  output logic                          overrange_flag_a_o,
  output logic                          overrange_flag_b_o,
  output logic                          overrange_flag_c_o,
  output logic                          overrange_flag_d_o,
  // status
  output logic                          init_done_o
);
  localparam int          CHANNELS = 4;
  localparam int          SHIFT_W  = `SFOC_SPI_SHIFT_W;
  localparam int          DATA_W   = `SFOC_DATA_W;
  localparam int          INIT_W   = $clog2(INIT_CYCLES + 1);
  localparam int          PIN_SCLK = 0;
  localparam int          PIN_CS_N = 1;
  localparam int          PIN_SDI  = 2;
  localparam int          PIN_SYNC = 3;
  localparam logic [3:0]  PIN_IDLE = 4'ha;

  // pin synchronisers
  logic [3:0]            pin_meta;
  logic [3:0]            pin_sync;
  logic                  sclk_prev;
  // serial frame
  sfoc_spi_state_e       state;
  sfoc_spi_state_e       next_state;
  logic [4:0]            bit_cnt;
  logic [SHIFT_W-1:0]    shift_in;
  logic [DATA_W-1:0]     shift_out;
  sfoc_spi_cmd_s         cmd;
  logic                  load_rd;
  logic                  wr_strobe;
  logic [DATA_W-1:0]     wr_data;
  logic                  sdo_oe;
  // registers
  logic [`SFOC_SYNC_LIM_MSB:0] sync_lim;
  logic [`SFOC_LEVEL_W-1:0]    ovr_level;
  sfoc_overrange_config_s               overrange_config;
  // init and link timing
  logic [INIT_W-1:0]     init_cnt;
  logic                  init_done;
  logic                  link_tick;
  logic [CHANNELS-1:0]   flags;

  // pin synchronisers: the first stage is read only by the second
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_meta  <= PIN_IDLE;
      pin_sync  <= PIN_IDLE;
      sclk_prev <= 1'b0;
    end else begin
      pin_meta  <= {sync_n_i, spi_sdi_i, spi_cs_n_i, spi_sclk_i};
      pin_sync  <= pin_meta;
      sclk_prev <= pin_sync[PIN_SCLK];
    end
  end

  // edge and frame decode; sclk must run well below clock_i / 4
  wire cs_active = !pin_sync[PIN_CS_N];
  wire sdi       = pin_sync[PIN_SDI];
  wire sclk_rise = pin_sync[PIN_SCLK] && !sclk_prev && cs_active;
  wire sclk_fall = !pin_sync[PIN_SCLK] && sclk_prev && cs_active;
  wire counting  = sclk_rise && (state != SFOC_DONE);
  wire cmd_last  = counting && (bit_cnt == `SFOC_SPI_CMD_LAST);
  wire data_last = counting && (bit_cnt == `SFOC_SPI_DATA_LAST);
  wire [SHIFT_W-1:0] next_shift = {shift_in[SHIFT_W-2:0], sdi};

  // frame phase sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      SFOC_IDLE: if (cs_active) next_state = SFOC_ADDR;
      SFOC_ADDR: if (cmd_last) next_state = SFOC_DATA;
      SFOC_DATA: if (data_last) next_state = SFOC_DONE;
      SFOC_DONE: next_state = SFOC_DONE;
    endcase
    if (!cs_active)
      next_state = SFOC_IDLE;
  end

  // phase register
  always_ff @(posedge clock_i) begin
    if (rst_i)
      state <= SFOC_IDLE;
    else
      state <= next_state;
  end

  // input shifter and bit counter, restarted by chip select
  always_ff @(posedge clock_i) begin
    if (rst_i || !cs_active) begin
      bit_cnt  <= '0;
      shift_in <= '0;
    end else if (counting) begin
      bit_cnt  <= bit_cnt + 5'h01;
      shift_in <= next_shift;
    end
  end

  // command capture and write strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmd       <= '0;
      load_rd   <= 1'b0;
      wr_strobe <= 1'b0;
      wr_data   <= '0;
    end else begin
      load_rd   <= cmd_last;
      // writes before init completes are dropped on purpose
      wr_strobe <= data_last && !cmd.is_read && init_done;
      if (cmd_last)
        cmd <= next_shift;
      if (data_last)
        wr_data <= next_shift[DATA_W-1:0];
    end
  end

  // address decode
  wire hit_sync = (cmd.addr == `SFOC_ADDR_SYNC);
  wire hit_lvl  = (cmd.addr == `SFOC_ADDR_OVR_LVL);
  wire hit_cfg  = (cmd.addr == `SFOC_ADDR_OVERRANGE_CONFIG);
  wire hit_init = (cmd.addr == `SFOC_ADDR_INIT);

  // readback, reserved bits and unmapped addresses read zero
  wire [DATA_W-1:0] rd_sync = {3'h0, sync_lim};
  wire [DATA_W-1:0] rd_lvl  = ovr_level;
  wire [DATA_W-1:0] rd_cfg  = {4'h0, overrange_config.enable, overrange_config.hold_exp};
  wire [DATA_W-1:0] rd_init = {7'h00, init_done};
  wire [DATA_W-1:0] rd_data = hit_sync ? rd_sync :
                              hit_lvl  ? rd_lvl  :
                              hit_cfg  ? rd_cfg  :
                              hit_init ? rd_init : 8'h00;

  // output shifter, msb first, changes on falling sclk
  always_ff @(posedge clock_i) begin
    if (rst_i || !cs_active) begin
      shift_out <= '0;
      sdo_oe    <= 1'b0;
    end else if (load_rd) begin
      shift_out <= rd_data;
      sdo_oe    <= cmd.is_read;
    end else if (sclk_fall && state == SFOC_DATA) begin
      shift_out <= {shift_out[DATA_W-2:0], 1'b0};
    end
  end

  assign spi_sdo_o    = shift_out[DATA_W-1];
  assign spi_sdo_oe_o = sdo_oe;

  // writable registers; reserved bits are not stored
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync_lim  <= `SFOC_RST_SYNC_LIM;
      ovr_level <= `SFOC_RST_OVR_LVL;
      overrange_config   <= '{enable: `SFOC_RST_OVERRANGE_OUTPUT_ENABLE, hold_exp: `SFOC_RST_OVR_EXP};
    end else if (wr_strobe) begin
      if (hit_sync)
        sync_lim <= wr_data[`SFOC_SYNC_LIM_MSB:0];
      if (hit_lvl)
        ovr_level <= wr_data;
      if (hit_cfg) begin
        overrange_config.enable   <= wr_data[`SFOC_OVERRANGE_OUTPUT_ENABLE_BIT];
        overrange_config.hold_exp <= wr_data[`SFOC_OVR_EXP_MSB:0];
      end
    end
  end

  // init sequencer: a fixed settle count stands in for internal start-up
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      init_cnt  <= '0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_cnt  <= init_cnt + INIT_W'(1);
      init_done <= (init_cnt == INIT_W'(INIT_CYCLES - 1));
    end
  end

  assign init_done_o = init_done;

  // link clock is half the sampling rate, an enable every second cycle
  always_ff @(posedge clock_i) begin
    if (rst_i)
      link_tick <= 1'b0;
    else
      link_tick <= !link_tick;
  end

  // sync request qualifier on the link tick
  sfoc_sync_qual #(
    .LIMIT_W (`SFOC_SYNC_LIM_MSB + 1)
  ) u_sync_qual (
    .clock_i        (clock_i),
    .rst_i          (rst_i),
    .link_tick_i    (link_tick),
    .link_enable_i  (link_enable_i),
    .sync_n_i       (pin_sync[PIN_SYNC]),
    .limit_i        (sync_lim),
    .request_o      (sync_request_o),
    .error_report_o (sync_error_report_o)
  );

  // one detector per channel, each driving only its own flag
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    sfoc_ovr_chan #(
      .SAMPLE_W (SAMPLE_W)
    ) u_chan (
      .clock_i  (clock_i),
      .rst_i    (rst_i),
      .sample_i (samples_i[ch]),
      .level_i  (ovr_level),
      .cfg_i    (overrange_config),
      .flag_o   (flags[ch])
    );
  end

  assign overrange_flag_a_o = flags[0];
  assign overrange_flag_b_o = flags[1];
  assign overrange_flag_c_o = flags[2];
  assign overrange_flag_d_o = flags[3];

  property p_init_sticks;
    @(posedge clock_i) disable iff (rst_i)
      init_done |=> init_done;
  endproperty
  a_init_sticks: assert property (p_init_sticks) else $error("init done dropped");

  property p_no_write_before_init;
    @(posedge clock_i) disable iff (rst_i)
      !init_done |=> $stable(ovr_level) && $stable(sync_lim) && $stable(overrange_config);
  endproperty
  a_no_write_before_init: assert property (p_no_write_before_init)
    else $error("write before init");

  property p_link_half_rate;
    @(posedge clock_i) disable iff (rst_i)
      link_tick |=> !link_tick ##1 link_tick;
  endproperty
  a_link_half_rate: assert property (p_link_half_rate) else $error("link tick rate");

  property p_all_low_disabled;
    @(posedge clock_i) disable iff (rst_i)
      !overrange_config.enable |=> (flags == '0);
  endproperty
  a_all_low_disabled: assert property (p_all_low_disabled) else $error("flags while off");

  property p_sdo_released;
    @(posedge clock_i) disable iff (rst_i)
      !cs_active |=> !spi_sdo_oe_o;
  endproperty
  a_sdo_released: assert property (p_sdo_released) else $error("sdo driven idle");
endmodule

// [sim/sfoc_rx_model.sv]
// receiver-side model that drives the active-low sync request line
`timescale 1ns/1ps
module sfoc_rx_model (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // commands from the bench
  input  wire logic       go_i,
  input  wire logic [7:0] low_len_i,
  input  wire logic       hold_i,
  // link side
  output logic            sync_n_o
);
  logic [7:0] left;

  // timed low run; the line is always driven, never left floating
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      left <= 8'h00;
    end else if (go_i) begin
      left <= low_len_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end

  // short runs are error reports, sent only when the bench commands one
  assign sync_n_o = !((left != 8'h00) || hold_i);
endmodule

// [sim/sfoc_top_tb.sv]
// self-checking bench for the sync qualifier, over-range and status slice
`timescale 1ns/1ps
`include "sfoc_map.svh"
module sfoc_top_tb;
  logic             clock_i;
  logic             rst_i;
  logic             sclk;
  logic             cs_n;
  logic             sdi;
  logic             link_en;
  logic             go;
  logic             hold;
  logic [7:0]       low_len;
  logic [3:0][11:0] samples;
  wire              sdo;
  wire              sdo_oe;
  wire              sync_n;
  wire              req;
  wire              errp;
  wire              init_done;
  wire  [3:0]       flags;
  int               n_errors;
  int               checks_done;
  int               n_req;
  int               n_errp;
  int               n;
  int               lim [3] = '{0, 3, 31};

  sfoc_top #(.SAMPLE_W(12), .INIT_CYCLES(16)) uut (
    .clock_i(clock_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .sync_n_i(sync_n),
    .link_enable_i(link_en), .sync_request_o(req), .sync_error_report_o(errp),
    .samples_i(samples), .overrange_flag_a_o(flags[0]), .overrange_flag_b_o(flags[1]),
    .overrange_flag_c_o(flags[2]), .overrange_flag_d_o(flags[3]),
    .init_done_o(init_done));

  sfoc_rx_model rx (.clock_i(clock_i), .rst_i(rst_i), .go_i(go), .low_len_i(low_len),
    .hold_i(hold), .sync_n_o(sync_n));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // cycles of request and error pulses seen on the link side
  always @(posedge clock_i) begin
    n_req += int'(req === 1'b1);
    n_errp += int'(errp === 1'b1);
  end

  task automatic close_out();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for request (1) or init done (0)
  task automatic wait_on(input bit sel, output int k);
    k = 0;
    while ((sel ? req : init_done) !== 1'b1) begin
      @(posedge clock_i);
      k++;
      if (k > 200) begin
        n_errors++;
        close_out();
      end
    end
  endtask

  // one frame; phases of 6 cycles keep clear of the 4-cycle minimum
  task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [23:0] w;
    w = {rd, a, d};
    q = 8'h00;
    cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi <= w[i];
      repeat (6) @(posedge clock_i);
      sclk <= 1'b1;
      repeat (6) @(posedge clock_i);
      // msb loads after the 16th rise and each fall shifts, so take a bit late in each high phase
      if (rd && i >= 1 && i <= 8) q[i-1] = (sdo_oe === 1'b1) ? sdo : 1'bx;
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clock_i);
    cs_n <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [15:0] e);
    logic [7:0] q;
    spi(1'b1, a, 8'h00, q);
    check({8'h00, q}, e);
  endtask

  // one-cycle sample on a channel, then count flag cycles on it and the others
  task automatic ovr(input int ch, input logic [11:0] s, input int w);
    int hi;
    int other;
    hi = 0;
    other = 0;
    samples[ch] <= s;
    @(posedge clock_i);
    samples[ch] <= 12'h000;
    repeat (w + 12) begin
      @(posedge clock_i);
      hi += int'(flags[ch] === 1'b1);
      other += int'((flags & ~(4'b0001 << ch)) !== 4'b0000);
    end
    check(16'(hi), 16'(w));
    check(16'(other), 16'h0000);
  endtask

  initial begin
    repeat (90000) @(posedge clock_i);
    n_errors++;
    close_out();
  end

  initial begin
    rst_i = 1'b1;
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    link_en = 1'b0;
    go = 1'b0;
    hold = 1'b0;
    low_len = 8'h00;
    samples = '0;
    repeat (8) @(posedge clock_i);
    check({15'h0000, init_done}, 16'h0000);
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    wait_on(1'b0, n);
    check(16'(n >= 15 && n <= 19), 16'h0001);
    // reset values, status and flags off at reset
    rd_chk(`SFOC_ADDR_SYNC, 16'h0003);
    rd_chk(`SFOC_ADDR_OVR_LVL, 16'h00f2);
    rd_chk(`SFOC_ADDR_OVERRANGE_CONFIG, 16'h0007);
    rd_chk(`SFOC_ADDR_INIT, 16'h0001);
    ovr(0, 12'h800, 0);
    // refused writes: status, unmapped; then sync and config writes
    wr(`SFOC_ADDR_INIT, 8'h00);
    rd_chk(`SFOC_ADDR_INIT, 16'h0001);
    wr(15'h0212, 8'hff);
    rd_chk(15'h0212, 16'h0000);
    wr(`SFOC_ADDR_SYNC, 8'h05);
    rd_chk(`SFOC_ADDR_SYNC, 16'h0005);
    wr(`SFOC_ADDR_OVERRANGE_CONFIG, 8'h06);
    rd_chk(`SFOC_ADDR_OVERRANGE_CONFIG, 16'h0006);
    // default level 242 means 1936 counts; both signs, boundary below
    wr(`SFOC_ADDR_OVERRANGE_CONFIG, 8'h08);
    ovr(1, 12'h78f, 0);
    ovr(1, 12'h790, 4);
    ovr(2, 12'h870, 4);
    foreach (lim[j]) begin
      wr(`SFOC_ADDR_OVERRANGE_CONFIG, 8'h08 | 8'(2 * j + 1));
      ovr(3, 12'h800, 4 << (2 * j + 1));
    end
    wr(`SFOC_ADDR_OVR_LVL, 8'h80);
    rd_chk(`SFOC_ADDR_OVR_LVL, 16'h0080);
    wr(`SFOC_ADDR_OVERRANGE_CONFIG, 8'h08);
    ovr(0, 12'h3ff, 0);
    ovr(0, 12'hc00, 4);
    wr(`SFOC_ADDR_OVERRANGE_CONFIG, 8'h00);
    ovr(0, 12'h800, 0);
    // limits 0, reset value and maximum; changed only with the link off
    foreach (lim[j]) begin
      link_en <= 1'b0;
      wr(`SFOC_ADDR_SYNC, 8'(lim[j]));
      rd_chk(`SFOC_ADDR_SYNC, 16'(lim[j]));
      link_en <= 1'b1;
      repeat (4) @(posedge clock_i);
      n_req = 0;
      n_errp = 0;
      // two short runs split by a high gap must not add up
      if (lim[j] > 0) begin
        repeat (2) begin
          go <= 1'b1;
          low_len <= 8'(2 * lim[j] - 1);
          @(posedge clock_i);
          go <= 1'b0;
          repeat (2 * lim[j] + 12) @(posedge clock_i);
        end
      end
      check(16'(n_errp), lim[j] > 0 ? 16'h0002 : 16'h0000);
      check(16'(n_req), 16'h0000);
      hold <= 1'b1;
      wait_on(1'b1, n);
      check(16'(n >= 2 * lim[j] + 3 && n <= 2 * lim[j] + 8), 16'h0001);
      hold <= 1'b0;
      repeat (8) @(posedge clock_i);
      check({15'h0000, req}, 16'h0000);
      check(16'(n_errp), lim[j] > 0 ? 16'h0002 : 16'h0000);
    end
    close_out();
  end
endmodule
